/* File: shared/spe_pkg.sv */
// Purpose: shared constants and types of the serial program execution engine
// Assumes: one system clock samples the serial pins; no software registers
// Notes: Overview of operation below lists the behaviour each tag refers to
//
// Overview of operation
// - forced no-op runs during first opcode fetch
// - no-op opcode holds cpu for 16-bit word
// - held cpu sits frozen in fourth phase
// - one-word first cycle overlaps next opcode fetch
// - dummy word after second no-op is ignored
// - after dummy word cpu runs second cycle
// - two-word first cycle overlaps next opcode fetch
// - word after second no-op is operand
// - operand done, second cycle overlaps next fetch
// - write opcode fetched during previous execution
// - write opcode collects sixteen data bits
// - first write cycle spans first four bits
// - write data not applied before second cycle
// - second write cycle programs word, fetches next
// - programming stops once serial clock is low
// - data latched on falling edge, lsb first
// - opcode 0000 no-op, 1100-1111 table writes
package spe_pkg;
   localparam int SPE_OP_W = 4;            // width of a serial opcode
   localparam int SPE_WORD_W = 16;         // width of an instruction or data word
   localparam int SPE_CNT_W = 5;           // bit counter width
   localparam logic [4:0] SPE_FETCH_LEN = 5'h04;   // bits in an opcode fetch
   localparam logic [4:0] SPE_WORD_LEN = 5'h10;    // bits in a full word shift
   localparam logic [4:0] SPE_TW_FIRST_LEN = 5'h04; // write data bits in first cycle
   localparam logic [4:0] SPE_TW_REST_LEN = 5'h0c;  // remaining write data bits
   localparam logic [3:0] SPE_OP_NOP = 4'h0;        // opcode of the no-op
   localparam logic [1:0] SPE_TW_MARK = 2'h3;       // upper opcode bits of table writes
   localparam logic [1:0] SPE_PHASE_FOURTH = 2'h3;  // fourth internal phase
   localparam int SPE_SYNC_W = 3;                   // clock, data, voltage pins

   // engine states
   typedef enum logic [2:0] {
      SPE_IDLE,
      SPE_FETCH,
      SPE_SHIFT_WORD,
      SPE_TW_FIRST,
      SPE_TW_REST
   } spe_state_t;

   // what the cpu executes during a fetch phase
   typedef enum logic [1:0] {
      SPE_EX_FORCED_NO_OP,
      SPE_EX_FIRST,
      SPE_EX_SECOND,
      SPE_EX_TW_SECOND
   } spe_exec_t;

   // word handed to the cpu after a 16-bit shift
   typedef struct packed {
      logic valid;                  // one-cycle strobe
      logic second;                 // dummy or operand for a second cycle
      logic [15:0] data;            // shifted word, lsb arrived first
   } spe_word_t;

   // table write handed to the memory
   typedef struct packed {
      logic start;                  // first cycle strobe
      logic commit;                 // second cycle strobe, data valid
      logic [1:0] ptr_mode;         // none, post-inc, post-dec, pre-inc
      logic [15:0] data;            // word to program
   } spe_twrite_t;
endpackage

/* File: verilog/spe_sync.sv */
// Purpose: two-flop synchroniser for the serial pins
// Assumes: inputs are asynchronous to clk_sys_in
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module spe_sync #(
   parameter int WIDTH = 3
)
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg; // first stage, may go metastable

   // one generate loop, one pair of flops per pin
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge clk_sys_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               meta_reg[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else if (ce_in)
            begin
               meta_reg[i] <= async_in[i];
               sync_out[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
endmodule

/* File: verilog/spe_engine.sv */
// Purpose: serial execution state machine of the programming mode
// Assumes: serial clock is far slower than clk_sys_in (160 ns vs 20 ns)
// Notes: table read flows are outside this block
`timescale 1ns/1ps
module spe_engine
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic serial_clock_pin_in,
   input wire logic serial_data_pin_in,
   input wire logic reset_program_voltage_pin_in,
   input wire logic cpu_two_cycle_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe_out,
   output logic mode_active_out,
   output logic cpu_hold_out,
   output logic [1:0] cpu_phase_out,
   output logic exec_start_out,
   output spe_pkg::spe_exec_t exec_kind_out,
   output spe_pkg::spe_word_t word_out,
   output spe_pkg::spe_twrite_t twrite_out,
   output logic program_enable_out
);
   import spe_pkg::*;

   logic [SPE_SYNC_W-1:0] pins_sync; // synchronised clock, data, voltage
   logic sclk; // synchronised serial clock
   logic sdat; // synchronised serial data
   logic vpp; // synchronised program voltage level
   logic sclk_prev_reg; // last serial clock sample
   logic fall; // falling serial clock edge
   spe_state_t state_reg;
   spe_state_t state_next;
   logic [SPE_CNT_W-1:0] cnt_reg; // bits latched in this phase
   logic [SPE_WORD_W-1:0] shift_reg; // lsb-first shifter
   logic [SPE_WORD_W-1:0] shift_next;
   logic [SPE_CNT_W-1:0] len; // length of current phase
   logic last; // falling edge that ends the phase
   logic [SPE_OP_W-1:0] opcode; // opcode completed by this edge
   logic second_pending_reg; // next word belongs to a second cycle
   logic [1:0] ptr_mode_reg; // pointer mode of the write in progress

   spe_sync #(
      .WIDTH(SPE_SYNC_W)
   ) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .async_in({reset_program_voltage_pin_in, serial_data_pin_in, serial_clock_pin_in}),
      .sync_out(pins_sync)
   );

   assign sclk = pins_sync[0];
   assign sdat = pins_sync[1];
   assign vpp = pins_sync[2];
   assign fall = sclk_prev_reg & ~sclk;
   assign shift_next = {sdat, shift_reg[SPE_WORD_W-1:1]};
   assign opcode = shift_next[SPE_WORD_W-1 -: SPE_OP_W];

   // phase length per state
   always_comb
   begin
      case (state_reg)
         SPE_FETCH: len = SPE_FETCH_LEN;
         SPE_SHIFT_WORD: len = SPE_WORD_LEN;
         SPE_TW_FIRST: len = SPE_TW_FIRST_LEN;
         SPE_TW_REST: len = SPE_TW_REST_LEN;
         default: len = SPE_FETCH_LEN;
      endcase
   end

   assign last = fall && (cnt_reg == len - 5'h01);

   // edge detector sits behind the synchroniser, never on its first stage
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         sclk_prev_reg <= 1'b0;
      else if (ce_in)
         sclk_prev_reg <= sclk;
   end

   // next state on the edge that closes a phase
   always_comb
   begin
      state_next = state_reg;
      if (!vpp)
         state_next = SPE_IDLE;
      else
      begin
         case (state_reg)
            SPE_IDLE:
               state_next = SPE_FETCH;
            SPE_FETCH:
               if (last)
               begin
                  // table writes skip the word shift, all else awaits a word
                  if (opcode[3:2] == SPE_TW_MARK)
                     state_next = SPE_TW_FIRST;
                  else
                     state_next = SPE_SHIFT_WORD;
               end
            SPE_SHIFT_WORD:
               if (last)
                  state_next = SPE_FETCH;
            SPE_TW_FIRST:
               if (last)
                  state_next = SPE_TW_REST;
            SPE_TW_REST:
               if (last)
                  state_next = SPE_FETCH;
            default:
               state_next = SPE_IDLE;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         state_reg <= SPE_IDLE;
      else if (ce_in)
         state_reg <= state_next;
   end

   // bit counter restarts at every phase boundary
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         cnt_reg <= '0;
      else if (ce_in)
      begin
         if (state_next != state_reg || last)
            cnt_reg <= '0;
         else if (fall && state_reg != SPE_IDLE)
            cnt_reg <= cnt_reg + 5'h01;
      end
   end

   // shifter; write data keeps filling across the 4 plus 12 split
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         shift_reg <= '0;
      else if (ce_in)
      begin
         if (state_reg == SPE_IDLE)
            shift_reg <= '0;
         else if (fall)
            shift_reg <= shift_next;
      end
   end

   // second-cycle bookkeeping, a first word the cpu flags as two-cycle leads to the second word
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         second_pending_reg <= 1'b0;
      else if (ce_in)
      begin
         if (state_reg == SPE_IDLE)
            second_pending_reg <= 1'b0;
         else if (state_reg == SPE_SHIFT_WORD && last)
            second_pending_reg <= ~second_pending_reg & cpu_two_cycle_in;
      end
   end

   // cpu execution control and phase
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cpu_hold_out <= 1'b1;
         cpu_phase_out <= SPE_PHASE_FOURTH;
         exec_start_out <= 1'b0;
         exec_kind_out <= SPE_EX_FORCED_NO_OP;
         mode_active_out <= 1'b0;
      end
      else if (ce_in)
      begin
         mode_active_out <= (state_next != SPE_IDLE);
         exec_start_out <= 1'b0;
         case (state_next)
            SPE_FETCH, SPE_TW_FIRST:
            begin
               cpu_hold_out <= 1'b0;
               // phase follows the bits of the four-clock cycle
               if (state_next != state_reg)
                  cpu_phase_out <= 2'h0;
               else if (fall)
                  cpu_phase_out <= cnt_reg[1:0] + 2'h1;
            end
            SPE_SHIFT_WORD, SPE_TW_REST:
            begin
               cpu_hold_out <= 1'b1;
               cpu_phase_out <= SPE_PHASE_FOURTH;
            end
            default:
            begin
               cpu_hold_out <= 1'b1;
               cpu_phase_out <= SPE_PHASE_FOURTH;
            end
         endcase
         if (state_reg == SPE_IDLE && state_next == SPE_FETCH)
         begin
            exec_start_out <= 1'b1;
            exec_kind_out <= SPE_EX_FORCED_NO_OP;
         end
         else if (state_reg == SPE_SHIFT_WORD && state_next == SPE_FETCH)
         begin
            exec_start_out <= 1'b1;
            exec_kind_out <= second_pending_reg ? SPE_EX_SECOND : SPE_EX_FIRST;
         end
         else if (state_reg == SPE_TW_REST && state_next == SPE_FETCH)
         begin
            exec_start_out <= 1'b1;
            exec_kind_out <= SPE_EX_TW_SECOND;
         end
      end
   end

   // word delivery; dummy or operand is flagged as second
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         word_out <= '0;
      else if (ce_in)
      begin
         word_out.valid <= 1'b0;
         if (state_reg == SPE_SHIFT_WORD && last && vpp)
         begin
            word_out.valid <= 1'b1;
            word_out.second <= second_pending_reg;
            word_out.data <= shift_next;
         end
      end
   end

   // table write: start on opcode, commit only when the second cycle begins
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         twrite_out <= '0;
         ptr_mode_reg <= 2'h0;
      end
      else if (ce_in)
      begin
         twrite_out.start <= 1'b0;
         twrite_out.commit <= 1'b0;
         if (state_reg == SPE_FETCH && state_next == SPE_TW_FIRST)
         begin
            twrite_out.start <= 1'b1;
            twrite_out.ptr_mode <= opcode[1:0];
            ptr_mode_reg <= opcode[1:0];
         end
         else if (state_reg == SPE_TW_REST && state_next == SPE_FETCH)
         begin
            twrite_out.commit <= 1'b1;
            twrite_out.ptr_mode <= ptr_mode_reg;
            twrite_out.data <= shift_next;
         end
      end
   end

   // program pulse lasts while the clock is high before the first fetch bit
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         program_enable_out <= 1'b0;
      else if (ce_in)
         program_enable_out <= vpp && state_reg == SPE_FETCH && cnt_reg == '0
            && exec_kind_out == SPE_EX_TW_SECOND && sclk && !fall;
   end

   // data pin stays an input throughout these sequences
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         serial_data_pin_out <= 1'b0;
         serial_data_pin_oe_out <= 1'b0;
      end
      else if (ce_in)
      begin
         serial_data_pin_out <= 1'b0;
         serial_data_pin_oe_out <= 1'b0;
      end
   end
endmodule

/* File: test/spe_monitor.sv */
// Purpose: timing checks on the engine outputs
// Assumes: ce_in high during checked traffic
// Notes: bound to every engine instance
`timescale 1ns/1ps
module spe_monitor
   import spe_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic serial_clock_pin_in,
   input wire logic reset_program_voltage_pin_in,
   input wire logic serial_data_pin_oe_out,
   input wire logic mode_active_out,
   input wire logic cpu_hold_out,
   input wire logic [1:0] cpu_phase_out,
   input wire logic exec_start_out,
   input wire spe_pkg::spe_exec_t exec_kind_out,
   input wire spe_pkg::spe_word_t word_out,
   input wire spe_pkg::spe_twrite_t twrite_out,
   input wire logic program_enable_out
);
   logic armed_reg; // write begun, commit allowed
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in || !ce_in);
   // five samples covers the two sync flops plus the output flop
   sequence clk_low_held;
      !serial_clock_pin_in [*5];
   endsequence
   sequence volt_off_held;
      !reset_program_voltage_pin_in [*5];
   endsequence
   // arm on write start, disarm on commit
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         armed_reg <= 1'b0;
      else if (twrite_out.start)
         armed_reg <= 1'b1;
      else if (twrite_out.commit)
         armed_reg <= 1'b0;
   end
   chk_pin_input: assert property (!serial_data_pin_oe_out)
      else $error("data pin driven");
   chk_hold_fourth: assert property (cpu_hold_out |-> cpu_phase_out == SPE_PHASE_FOURTH)
      else $error("held cpu not in fourth phase");
   chk_word_release: assert property (
      word_out.valid |-> exec_start_out && !cpu_hold_out && cpu_phase_out == 2'h0)
      else $error("word not released to cpu");
   chk_word_kind: assert property (
      word_out.valid |-> exec_kind_out == (word_out.second ? SPE_EX_SECOND : SPE_EX_FIRST))
      else $error("word execution kind wrong");
   chk_commit_kind: assert property (
      twrite_out.commit |-> exec_start_out && !cpu_hold_out && exec_kind_out == SPE_EX_TW_SECOND)
      else $error("write commit without second cycle");
   chk_commit_order: assert property (twrite_out.commit |-> armed_reg)
      else $error("commit without write start");
   chk_start_gap: assert property (twrite_out.start |=> !twrite_out.commit [*8])
      else $error("commit too soon after start");
   chk_prog_stop: assert property (clk_low_held |-> !program_enable_out)
      else $error("programming with clock low");
   chk_mode_off: assert property (volt_off_held |-> !mode_active_out && cpu_hold_out)
      else $error("active without program voltage");
endmodule
bind spe_engine spe_monitor spe_monitor_inst (.*);

/* File: test/spe_programmer.sv */
// Purpose: behavioural serial programmer on the link pins
// Assumes: half period of the serial clock is 80 ns
// Notes: data line flips once its hold time is over
`timescale 1ns/1ps
module spe_programmer #(
   parameter int PULSE_NS = 4000, // programming pulse, shortened
   parameter int DISCH_NS = 2000 // discharge time, shortened
)
(
   output logic sclk_out,
   output logic sdat_out,
   output logic vpp_out
);
   // all pins low before mode entry
   initial
   begin
      sclk_out = 1'b0;
      sdat_out = 1'b0;
      vpp_out = 1'b0;
   end
   // odd offset keeps link phase unrelated to the system clock
   task enter;
      #37 vpp_out = 1'b1;
      #200;
   endtask
   // clock stands low between calls
   task send(input logic [15:0] v, input int n);
      int i;
      for (i = 0; i < n; i++)
      begin
         sclk_out = 1'b1;
         sdat_out = v[i];
         #80 sclk_out = 1'b0;
         #60 sdat_out = ~v[i];
         #20;
      end
   endtask
   // first bit of the opcode after a write, a zero
   task pulse;
      sclk_out = 1'b1;
      sdat_out = 1'b0;
      #PULSE_NS sclk_out = 1'b0;
      #60 sdat_out = 1'b1;
      #(DISCH_NS - 60);
   endtask
   task leave;
      vpp_out = 1'b0;
   endtask
endmodule

/* File: test/tb_serial_program_exec_engine.sv */
// Purpose: self-checking bench for the execution engine
// Assumes: ce_in high except in the closing freeze test
// Notes: rows cover opcodes, hand tests the two-cycle and pulse flows
`timescale 1ns/1ps
module tb_serial_program_exec_engine;
   import spe_pkg::*;
   typedef struct packed {logic [3:0] op; logic [15:0] d; logic [19:0] exp;} spe_row_t;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic ce = 1'b1; // clock enable, dropped once to test the freeze
   logic two_cycle = 1'b0; // cpu says last word is two-cycle
   logic sclk, pdat, vpp, dout, doe, mode, hold, prog_en, xs;
   logic [1:0] phase;
   spe_exec_t kind;
   spe_word_t word;
   spe_twrite_t tw;
   logic [19:0] cap; // kind and payload of the last event
   int evn = 0;
   int n0;
   int miscompares = 0;
   int comparisons = 0;
   // expected: kind, ptr mode or second flag, data word
   spe_row_t rows [6] = '{'{4'hc, 16'h1234, 20'hc1234}, '{4'h0, 16'ha5c3, 20'h4a5c3},
      '{4'hd, 16'h8001, 20'hd8001}, '{4'h5, 16'h3c3c, 20'h43c3c},
      '{4'he, 16'hfffe, 20'hefffe}, '{4'hf, 16'h0f0f, 20'hf0f0f}};
   always #10 clk_sys_in = ~clk_sys_in;
   spe_programmer spe_programmer_inst (.sclk_out(sclk), .sdat_out(pdat), .vpp_out(vpp));
   spe_engine spe_engine_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
      .serial_clock_pin_in(sclk), .serial_data_pin_in(doe ? dout : pdat),
      .reset_program_voltage_pin_in(vpp), .cpu_two_cycle_in(two_cycle),
      .serial_data_pin_out(dout), .serial_data_pin_oe_out(doe), .mode_active_out(mode),
      .cpu_hold_out(hold), .cpu_phase_out(phase), .exec_start_out(xs),
      .exec_kind_out(kind), .word_out(word), .twrite_out(tw), .program_enable_out(prog_en));
   // capture each delivered word or write commit
   always @(negedge clk_sys_in)
   begin
      if (word.valid || tw.commit)
      begin
         cap = word.valid ? {kind, 1'b0, word.second, word.data} : {kind, tw.ptr_mode, tw.data};
         evn++;
      end
   end
   task check(input string what, input logic [19:0] seen, input logic [19:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task conclude;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // bounded wait for a new event
   task await;
      int i;
      for (i = 0; i < 100 && evn == n0; i++)
         @(negedge clk_sys_in);
      if (evn == n0)
      begin
         miscompares++;
         conclude;
      end
   endtask
   task xfer(input logic [3:0] op, input logic [15:0] d);
      n0 = evn;
      spe_programmer_inst.send({12'h000, op}, 4);
      spe_programmer_inst.send(d, 16);
      await;
   endtask
   initial
   begin
      int i;
      repeat (5) @(negedge clk_sys_in);
      check("reset", 20'({hold, mode, doe, dout, phase, xs}), 20'h00046);
      rst_in = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      spe_programmer_inst.enter;
      check("entry", 20'({mode, hold, phase, kind}), 20'h00020);
      // writes decode ptr mode from the low opcode bits, the rest take a word
      for (i = 0; i < 6; i++)
      begin
         xfer(rows[i].op, rows[i].d);
         check("row", cap, rows[i].exp);
      end
      // two-cycle word then operand word
      @(negedge clk_sys_in) two_cycle = 1'b1;
      xfer(4'h0, 16'h7e81);
      check("first", cap, {SPE_EX_FIRST, 2'b00, 16'h7e81});
      @(negedge clk_sys_in) two_cycle = 1'b0;
      n0 = evn;
      spe_programmer_inst.send(16'h0000, 4);
      spe_programmer_inst.send(16'h00c3, 8);
      check("held", 20'({hold, phase, doe, dout}), 20'h0001c);
      spe_programmer_inst.send(16'h00b4, 8);
      await;
      check("second", cap, {SPE_EX_SECOND, 2'b01, 16'hb4c3});
      // write, then programming pulse on the next opcode
      n0 = evn;
      spe_programmer_inst.send(16'h000c, 4);
      spe_programmer_inst.send(16'h0005, 4);
      check("early commit", 20'(evn), 20'(n0));
      spe_programmer_inst.send(16'h00a9, 12);
      await;
      check("write", cap, {SPE_EX_TW_SECOND, 2'b00, 16'h0a95});
      fork
         spe_programmer_inst.pulse;
         #2000 check("pulse on", 20'(prog_en), 20'h00001);
      join
      check("pulse off", 20'(prog_en), 20'h00000);
      spe_programmer_inst.send(16'h0000, 3);
      n0 = evn;
      spe_programmer_inst.send(16'h1111, 16);
      await;
      check("after pulse", cap, {SPE_EX_FIRST, 2'b00, 16'h1111});
      spe_programmer_inst.leave;
      repeat (8) @(negedge clk_sys_in);
      check("mode off", 20'({mode, hold}), 20'h00001);
      // a low clock enable must freeze the synchronisers and the state
      @(negedge clk_sys_in) ce = 1'b0;
      spe_programmer_inst.enter;
      check("frozen", 20'({mode, hold}), 20'h00001);
      @(negedge clk_sys_in) ce = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      check("resumed", 20'({mode, hold}), 20'h00002);
      spe_programmer_inst.leave;
      conclude;
   end
endmodule
